// ### core/rmcv_core.sv
// Purpose: system reset and machine check exception recognition and vectoring
// Assumes: core asks for a resume address and machine state; ce low freezes all state
// Notes:   one exception is taken per save cycle; reset beats machine check
`timescale 1ns/1ps
module rmcv_core #(
    parameter int unsigned ADDR_W = rmcv_pkg::ADDR_W,
    parameter int unsigned MSW_W  = rmcv_pkg::MSW_W
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              ce,
    input  wire logic              soft_reset_pin,
    input  wire logic              hard_reset_pin,
    input  wire logic              machine_check_input,
    input  wire logic              transfer_error_ack,
    input  wire logic [1:0]        bus_op,
    input  wire logic              bus_op_own,
    input  wire logic              addr_parity_err,
    input  wire logic              data_parity_err,
    input  wire logic              icache_parity_err,
    input  wire logic              dcache_parity_err,
    input  wire logic              state_corrupt,
    input  wire logic [ADDR_W-1:0] resume_addr,
    input  wire logic [MSW_W-1:0]  state_wr_data,
    input  wire logic              state_wr,
    output logic [MSW_W-1:0]       machine_state_reg,
    output logic [ADDR_W-1:0]      saved_return_address,
    output logic [MSW_W-1:0]       saved_status_copy,
    output logic [ADDR_W-1:0]      vector_addr,
    output logic                   vector_take,
    output logic                   checkstop
);
    rmcv_sync_if sync ();

    rmcv_pin_sync u_sync (
        .clk            (clk),
        .resetn         (resetn),
        .ce             (ce),
        .soft_reset_pin (soft_reset_pin),
        .hard_reset_pin (hard_reset_pin),
        .mcheck_pin     (machine_check_input),
        .sync           (sync)
    );

    function automatic logic own_op_ok(input logic [1:0] op, input logic own);
        own_op_ok = own && (op != rmcv_pkg::RMCV_OP_NONE);
    endfunction

    rmcv_pkg::rmcv_state_t state_q;
    rmcv_pkg::rmcv_state_t state_d;
    logic              reset_cause;
    logic              mc_cause;
    logic              bus_err_ok;
    logic              mc_enable;
    logic              take_reset;
    logic              take_mc;
    logic              corrupt_q;
    logic              is_reset_q;
    logic              rst_lvl_q;
    logic [MSW_W-1:0]  save_copy;

    // bus error is meaningless on snoops or foreign masters
    assign bus_err_ok  = transfer_error_ack && own_op_ok(bus_op, bus_op_own);
    assign reset_cause = sync.soft_reset || sync.hard_reset;
    assign mc_cause    = bus_err_ok || sync.machine_check_input
                       || addr_parity_err || data_parity_err
                       || icache_parity_err || dcache_parity_err;
    assign mc_enable   = machine_state_reg[rmcv_pkg::MCE_BIT];
    // reset level is edge-taken so a held pin yields one exception
    assign take_reset  = reset_cause && !rst_lvl_q;
    assign take_mc     = mc_cause && mc_enable && !take_reset;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rmcv_pkg::RMCV_RUN: begin
                if (take_reset || take_mc) begin
                    state_d = rmcv_pkg::RMCV_SAVE;
                end else if (mc_cause && !mc_enable) begin
                    state_d = rmcv_pkg::RMCV_STOP;
                end
            end
            rmcv_pkg::RMCV_SAVE: begin
                state_d = rmcv_pkg::RMCV_RUN;
            end
            rmcv_pkg::RMCV_STOP: begin
                // only a reset leaves checkstop
                if (take_reset) begin
                    state_d = rmcv_pkg::RMCV_SAVE;
                end
            end
            default: state_d = rmcv_pkg::RMCV_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= rmcv_pkg::RMCV_RUN;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_lvl_q <= 1'b0;
        end else if (ce) begin
            rst_lvl_q <= reset_cause;
        end
    end

    always_comb begin
        save_copy = machine_state_reg;
        if (state_corrupt) begin
            save_copy[rmcv_pkg::RECOV_BIT] = 1'b0;
        end
    end

    // context save happens in the cycle the cause is accepted, vector follows
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            saved_return_address <= rmcv_pkg::ADDR_RESET;
            saved_status_copy    <= rmcv_pkg::MSW_RESET;
            is_reset_q           <= 1'b0;
            corrupt_q            <= 1'b0;
        end else if (ce && state_d == rmcv_pkg::RMCV_SAVE) begin
            saved_return_address <= resume_addr;
            saved_status_copy    <= save_copy;
            is_reset_q           <= take_reset;
            corrupt_q            <= state_corrupt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            machine_state_reg <= rmcv_pkg::MSW_RESET;
        end else if (ce) begin
            if (state_d == rmcv_pkg::RMCV_SAVE) begin
                machine_state_reg[rmcv_pkg::MCE_BIT] <= 1'b0;
            end else if (state_wr) begin
                machine_state_reg <= state_wr_data;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vector_take <= 1'b0;
            vector_addr <= rmcv_pkg::ADDR_RESET;
            checkstop   <= 1'b0;
        end else if (ce) begin
            vector_take <= (state_q == rmcv_pkg::RMCV_SAVE);
            if (state_q == rmcv_pkg::RMCV_SAVE) begin
                vector_addr <= is_reset_q ? rmcv_pkg::VEC_RESET : rmcv_pkg::VEC_MCHECK;
            end
            checkstop <= (state_d == rmcv_pkg::RMCV_STOP);
        end
    end

    // assertions
    property p_vec_reset;
        @(posedge clk) disable iff (!resetn)
        (ce && take_reset && state_q != rmcv_pkg::RMCV_SAVE) ##1 ce [*1] |=>
            (vector_take && vector_addr == rmcv_pkg::VEC_RESET);
    endproperty
    a_vec_reset: assert property (p_vec_reset) else $error("reset vector not taken");

    property p_recov_clear;
        @(posedge clk) disable iff (!resetn)
        (ce && state_d == rmcv_pkg::RMCV_SAVE && state_corrupt) |=>
            !saved_status_copy[rmcv_pkg::RECOV_BIT];
    endproperty
    a_recov_clear: assert property (p_recov_clear) else $error("recoverable copy kept");

    property p_vec_mc;
        @(posedge clk) disable iff (!resetn)
        (ce && take_mc && state_q == rmcv_pkg::RMCV_RUN) ##1 ce |=>
            (vector_take && vector_addr == rmcv_pkg::VEC_MCHECK);
    endproperty
    a_vec_mc: assert property (p_vec_mc) else $error("machine check vector wrong");

    property p_cstop;
        @(posedge clk) disable iff (!resetn)
        (ce && state_q == rmcv_pkg::RMCV_RUN && mc_cause && !mc_enable && !take_reset) |=>
            (checkstop && !vector_take);
    endproperty
    a_cstop: assert property (p_cstop) else $error("checkstop not entered");

    property p_enable_clr;
        @(posedge clk) disable iff (!resetn)
        (ce && vector_take) |-> !machine_state_reg[rmcv_pkg::MCE_BIT] || $past(state_wr);
    endproperty
    a_enable_clr: assert property (p_enable_clr) else $error("enable bit still set");

    property p_parity;
        @(posedge clk) disable iff (!resetn)
        (ce && state_q == rmcv_pkg::RMCV_RUN && mc_enable && !take_reset
            && (addr_parity_err || dcache_parity_err)) |=> state_q == rmcv_pkg::RMCV_SAVE;
    endproperty
    a_parity: assert property (p_parity) else $error("parity did not trap");

    property p_bus_err_qual;
        @(posedge clk) disable iff (!resetn)
        (ce && state_q == rmcv_pkg::RMCV_RUN && !bus_op_own && !take_reset
            && !sync.machine_check_input && !addr_parity_err && !data_parity_err
            && !icache_parity_err && !dcache_parity_err) |=> state_q == rmcv_pkg::RMCV_RUN;
    endproperty
    a_bus_err_qual: assert property (p_bus_err_qual) else $error("foreign bus error trapped");

    property p_save;
        @(posedge clk) disable iff (!resetn)
        (ce && state_d == rmcv_pkg::RMCV_SAVE) |=> saved_return_address == $past(resume_addr);
    endproperty
    a_save: assert property (p_save) else $error("resume address not saved");
endmodule

// ### core/rmcv_pin_sync.sv
// Purpose: three-stage synchroniser for asynchronous pin inputs
// Assumes: pins are active high levels
// Notes:   a change is accepted only when stages two and three agree
`timescale 1ns/1ps
module rmcv_pin_sync (
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    input  wire logic  soft_reset_pin,
    input  wire logic  hard_reset_pin,
    input  wire logic  mcheck_pin,
    rmcv_sync_if.src   sync
);
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] lvl_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q  <= 3'h0;
            s2_q  <= 3'h0;
            s3_q  <= 3'h0;
            lvl_q <= 3'h0;
        end else if (ce) begin
            s1_q <= {mcheck_pin, hard_reset_pin, soft_reset_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            // glitch filter: only stages two and three are compared
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end

    assign sync.soft_reset          = lvl_q[0];
    assign sync.hard_reset          = lvl_q[1];
    assign sync.machine_check_input = lvl_q[2];
endmodule

// ### include/rmcv_pkg.sv
// Purpose: shared constants and types for the reset / machine check vectoring unit
// Assumes: 32-bit effective addresses, 32-bit machine state word
// Notes:   bit positions of the machine state word are parameters of this package
package rmcv_pkg;
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned MSW_W       = 32;
    // exception vector offsets
    localparam logic [ADDR_W-1:0] VEC_RESET  = 32'h0000_0100;
    localparam logic [ADDR_W-1:0] VEC_MCHECK = 32'h0000_0200;
    // machine state word field positions
    localparam int unsigned MCE_BIT     = 12;
    localparam int unsigned RECOV_BIT   = 1;
    // reset values
    localparam logic [MSW_W-1:0]  MSW_RESET  = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    // bus operation kinds
    typedef enum logic [1:0] {
        RMCV_OP_NONE  = 2'h0,
        RMCV_OP_READ  = 2'h1,
        RMCV_OP_WRITE = 2'h2,
        RMCV_OP_FETCH = 2'h3
    } rmcv_op_t;
    // controller states, one-hot
    typedef enum logic [2:0] {
        RMCV_RUN  = 3'h1,
        RMCV_SAVE = 3'h2,
        RMCV_STOP = 3'h4
    } rmcv_state_t;
endpackage

// ### include/rmcv_sync_if.sv
// Purpose: carries synchronised pin levels from the synchroniser to the controller
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
interface rmcv_sync_if;
    logic soft_reset;
    logic hard_reset;
    logic machine_check_input;
    modport src (output soft_reset, output hard_reset, output machine_check_input);
    modport dst (input soft_reset, input hard_reset, input machine_check_input);
endinterface

// ### verif/rmcv_bus_model.sv
// Purpose: far side bus model, memory controller answering transfers
// Assumes: requests come from the bench on the falling edge, one transfer per request
// Notes:   error ack only rides on a transfer, never alone
`timescale 1ns/1ps
module rmcv_bus_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [1:0] op,
    input  wire logic       own,
    input  wire logic       bad,
    output logic            transfer_error_ack,
    output logic [1:0]      bus_op,
    output logic            bus_op_own
);
    // follows the request lines directly, so there is no race with the bench's
    // own falling-edge drive; the core samples it at the next rising edge
    assign bus_op             = go ? op : 2'h0;
    assign bus_op_own         = go ? own : 1'b0;
    // memory fault reported on the current transfer only
    assign transfer_error_ack = go && bad;
endmodule

// ### verif/rmcv_core_tb.sv
// Purpose: self-checking bench for the vectoring core
// Assumes: pins held long enough to pass the synchroniser
// Notes:   one scenario drops ce to show that pins are not seen while frozen
`timescale 1ns/1ps
module rmcv_core_tb;
    logic        clk, resetn, ce, go, own, bad, sr, hr, mci, corrupt, wr;
    logic [1:0]  op;
    logic [31:0] ra, wd, st, sra, ssc, vec;
    logic        bus_err, bop_own, take, cstop;
    logic [1:0]  bop;
    logic        ap, dp, ip, cp;
    int          n_errors, compares;
    localparam logic [31:0] MR = (32'h1 << rmcv_pkg::MCE_BIT) | (32'h1 << rmcv_pkg::RECOV_BIT);
    rmcv_bus_model i_rmcv_bus_model (.clk(clk), .go(go), .op(op), .own(own), .bad(bad),
        .transfer_error_ack(bus_err), .bus_op(bop), .bus_op_own(bop_own));
    rmcv_core i_rmcv_core (.clk(clk), .resetn(resetn), .ce(ce), .soft_reset_pin(sr),
        .hard_reset_pin(hr), .machine_check_input(mci), .transfer_error_ack(bus_err),
        .bus_op(bop), .bus_op_own(bop_own), .addr_parity_err(ap), .data_parity_err(dp),
        .icache_parity_err(ip), .dcache_parity_err(cp), .state_corrupt(corrupt),
        .resume_addr(ra), .state_wr_data(wd), .state_wr(wr), .machine_state_reg(st),
        .saved_return_address(sra), .saved_status_copy(ssc), .vector_addr(vec),
        .vector_take(take), .checkstop(cstop));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic take_vec(input logic [31:0] v);
        logic seen;
        seen = 1'b0;
        repeat (30) begin
            @(negedge clk);
            if (!seen && take === 1'b1) begin
                seen = 1'b1;
                chk("vector_addr", v, vec);
            end
        end
        chk("vector_take", 1, seen);
    endtask
    task automatic no_take(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) @(negedge clk) if (take !== 1'b0) seen = 1'b1;
        chk("no vector_take", 0, seen);
    endtask
    task automatic set_me();
        @(negedge clk);
        wr = 1'b1;
        wd = MR;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // one cycle cause: 0..2 own bus ops with error, 3..6 parity errors
    task automatic cause(input int k);
        @(negedge clk);
        go  = k < 3;
        op  = 2'(k + 1);
        own = 1'b1;
        bad = 1'b1;
        {ap, dp, ip, cp} = 4'h8 >> (k - 3);
        if (k < 3) {ap, dp, ip, cp} = 4'h0;
        @(negedge clk);
        go = 1'b0;
        {ap, dp, ip, cp} = 4'h0;
    endtask
    // short hold: the vector pulse comes after the return, so the caller still sees it
    task automatic pin(ref logic p);
        @(negedge clk);
        p = 1'b1;
        repeat (3) @(negedge clk);
        p = 1'b0;
    endtask
    task automatic t_reset_vals();
        chk("machine_state_reg", rmcv_pkg::MSW_RESET, st);
        chk("checkstop", 0, cstop);
        chk("saved_return_address", rmcv_pkg::ADDR_RESET, sra);
        chk("saved_status_copy", rmcv_pkg::MSW_RESET, ssc);
        chk("vector_take", 0, take);
    endtask
    task automatic t_stop_soft();
        pin(mci);
        no_take(10);
        chk("checkstop", 1, cstop);
        pin(sr);
        take_vec(rmcv_pkg::VEC_RESET);
        chk("checkstop", 0, cstop);
        chk("enable bit", 0, st[rmcv_pkg::MCE_BIT]);
    endtask
    task automatic t_bus_ops();
        for (int k = 0; k < 3; k++) begin
            set_me();
            ra = 32'h0000_1000 + 32'(k * 4);
            cause(k);
            take_vec(rmcv_pkg::VEC_MCHECK);
            chk("saved_return_address", ra, sra);
            chk("saved_status_copy", MR, ssc);
            chk("enable bit", 0, st[rmcv_pkg::MCE_BIT]);
        end
    endtask
    task automatic t_unqual();
        set_me();
        @(negedge clk);
        go  = 1'b1;
        op  = 2'h1;
        own = 1'b0;
        bad = 1'b1;
        @(negedge clk);
        op  = 2'h0;
        own = 1'b1;
        @(negedge clk);
        go = 1'b0;
        no_take(10);
        chk("checkstop", 0, cstop);
    endtask
    task automatic t_parity();
        for (int k = 3; k < 7; k++) begin
            set_me();
            corrupt = k == 6;
            cause(k);
            take_vec(rmcv_pkg::VEC_MCHECK);
            chk("recoverable_flag copy", k != 6, ssc[rmcv_pkg::RECOV_BIT]);
            corrupt = 1'b0;
        end
    endtask
    task automatic t_hard();
        set_me();
        corrupt = 1'b1;
        pin(hr);
        take_vec(rmcv_pkg::VEC_RESET);
        chk("recoverable_flag copy", 0, ssc[rmcv_pkg::RECOV_BIT]);
        corrupt = 1'b0;
    endtask
    // the pin pulse while frozen must leave no trace; the same pulse afterwards traps
    task automatic t_freeze();
        set_me();
        ce = 1'b0;
        pin(mci);
        no_take(4);
        ce = 1'b1;
        chk("enable bit", 1, st[rmcv_pkg::MCE_BIT]);
        no_take(6);
        pin(mci);
        take_vec(rmcv_pkg::VEC_MCHECK);
        chk("enable bit", 0, st[rmcv_pkg::MCE_BIT]);
    endtask
    task automatic t_mid_reset();
        set_me();
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        t_reset_vals();
    endtask
    initial begin
        {resetn, go, own, bad, sr, hr, mci, corrupt, wr, ap, dp, ip, cp} = '0;
        ce = 1'b1;
        op = 2'h0;
        ra = 32'h0000_0400;
        wd = 32'h0;
        n_errors = 0;
        compares = 0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        t_reset_vals();
        t_stop_soft();
        t_bus_ops();
        t_unqual();
        t_parity();
        t_hard();
        t_freeze();
        t_mid_reset();
        wrap_up();
    end
    // whole sequence is well under 1000 cycles
    initial begin
        #(40 * 3000);
        n_errors++;
        wrap_up();
    end
endmodule
